// ---- shared/acd_pkg.sv ----
// Package with register map, field layout, reset values and state types of the ADC clock divider.
package acd_pkg;

  // Printed register offsets are register indices; byte address is four times the index.
  localparam logic [9:0] ACD_IDX_RATIO_CONTROL = 10'h108;
  localparam logic [9:0] ACD_IDX_LOCAL_PHASE = 10'h109;
  localparam logic [9:0] ACD_IDX_SYNC_CONTROL = 10'h10A;
  localparam logic [9:0] ACD_IDX_CAPTURED_PHASE = 10'h129;
  localparam logic [9:0] ACD_IDX_STATUS = 10'h130;

  // APB geometry.
  localparam int ACD_ADDR_W = 12;
  localparam int ACD_DATA_W = 32;
  localparam int ACD_IDX_LSB = 2;

  // Field positions.
  localparam int ACD_RATIO_LSB = 0;
  localparam int ACD_PHASE_LSB = 0;
  localparam int ACD_AUTOPHASE_BIT = 7;
  localparam int ACD_CAPT_LSB = 0;
  localparam int ACD_STAT_HALF_LSB = 0;
  localparam int ACD_STAT_DIV_BIT = 4;
  localparam int ACD_STAT_AUTO_BIT = 5;
  localparam int ACD_STAT_EFF_LSB = 8;
  localparam int ACD_STAT_CNT_LSB = 16;

  // Reset values.
  localparam logic [1:0] ACD_RATIO_RESET = 2'h0;
  localparam logic [3:0] ACD_PHASE_RESET = 4'h0;
  localparam logic ACD_AUTOPHASE_RESET = 1'b0;
  localparam logic [3:0] ACD_CAPT_RESET = 4'h0;

  // Divider ratio codes.
  localparam logic [1:0] ACD_RATIO_DIV1 = 2'b00;
  localparam logic [1:0] ACD_RATIO_DIV2 = 2'b01;
  localparam logic [1:0] ACD_RATIO_DIV4 = 2'b11;

  // Phase offset codes with a named meaning.
  localparam logic [3:0] ACD_PHASE_NONE = 4'b0000;
  localparam logic [3:0] ACD_PHASE_INVERT = 4'b0001;

  // State of the pin synchroniser.
  typedef struct packed {
    logic meta_reg;
    logic level_reg;
    logic prev_reg;
  } acd_sync_state_t;

  // State of the divider and its register file.
  typedef struct packed {
    logic [1:0] ratio_code_reg;
    logic [3:0] local_phase_reg;
    logic autophase_en_reg;
    logic [3:0] captured_phase_reg;
    logic [2:0] half_count_reg;
    logic div_clk_reg;
    logic div_rise_reg;
    logic [7:0] sysref_count_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
  } acd_state_t;

endpackage

// ---- verilog/acd_pin_sync.sv ----
// Two-stage synchroniser for a pin with rising and any-edge pulse outputs.
`timescale 1ns/1ps

module acd_pin_sync (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous pin.
  input wire logic pin_in,
  // Synchronised level and edge pulses.
  output logic level,
  output logic rise,
  output logic any_edge
);
  import acd_pkg::*;

  acd_sync_state_t state_reg;
  acd_sync_state_t state_next;

  // Shift the pin through two flops and a third that holds the previous level; the second and third flops feed edge logic.
  always_comb begin
    state_next = state_reg;
    state_next.meta_reg = pin_in;
    state_next.level_reg = state_reg.meta_reg;
    state_next.prev_reg = state_reg.level_reg;
  end

  // Register the synchroniser state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Edge pulses compare two settled stages.
  assign level = state_reg.level_reg;
  assign rise = state_reg.level_reg & ~state_reg.prev_reg;
  assign any_edge = state_reg.level_reg ^ state_reg.prev_reg;

endmodule

// ---- verilog/acd_divider.sv ----
// Input clock divider with half-cycle phase offset and SYSREF autophase, behind an APB slave.
//
// Overview of operation
// RULE1 - Divide sample clock by 1, 2, 4.
// RULE2 - Offset 0000 gives no delay.
// RULE3 - Offset 0001 delays half cycle, inverted clock.
// RULE4 - 0010 delays one cycle, each step half.
// RULE5 - 1110 delays seven, 1111 seven and half.
// RULE6 - Autophase on: capture divider phase at SYSREF.
// RULE7 - Effective offset is captured plus local offset.
// RULE8 - Autophase off: SYSREF leaves phase unchanged.
// RULE9 - Autophase on: realign phase every SYSREF.
`timescale 1ns/1ps

module acd_divider (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acd_pkg::ACD_ADDR_W-1:0] paddr,
  input wire logic [acd_pkg::ACD_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [acd_pkg::ACD_DATA_W-1:0] prdata,
  // Sample clock and SYSREF pins.
  input wire logic sample_clk_in,
  input wire logic sysref_in,
  // Divided clock.
  output logic div_clk_out,
  output logic div_rise_out
);
  import acd_pkg::*;

  acd_state_t state_reg;
  acd_state_t state_next;

  logic sclk_edge;
  logic sysref_rise;

  // The sample clock pin is synchronised; each of its edges marks one half input cycle.
  // The pin is oversampled by pclk, so each of its levels must stand for at least two pclk cycles.
  // A faster sample clock would lose edges here and the divider would slip its phase.
  acd_pin_sync u_sclk_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(sample_clk_in),
    .level(),
    .rise(),
    .any_edge(sclk_edge)
  );

  // The SYSREF pin is synchronised; only its rising edge is an event.
  // The pin must stay high for at least two pclk cycles to be seen; a longer pulse still counts once.
  acd_pin_sync u_sysref_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(sysref_in),
    .level(),
    .rise(sysref_rise),
    .any_edge()
  );

  // Number of half input cycles in one divided period, less one, used as a mask.
  // The period is two, four or eight half cycles, so the mask is one less than a power of two.
  function automatic logic [3:0] period_mask(input logic [1:0] code);
    logic [3:0] mask;
    mask = 4'h1;
    unique case (code)
      ACD_RATIO_DIV2: mask = 4'h3;
      ACD_RATIO_DIV4: mask = 4'h7;
      default: mask = 4'h1;
    endcase
    return mask;
  endfunction

  // The divided clock is high in the first half of its period.
  // With a ratio of one this reproduces the input clock, high for its first half cycle.
  function automatic logic phase_high(input logic [3:0] phase, input logic [1:0] code);
    logic [3:0] half_period;
    half_period = (period_mask(code) >> 1) + 4'h1;
    return phase < half_period;
  endfunction

  // Decoded APB signals, the SYSREF capture event and the divider offset and phase signals.
  logic [9:0] reg_idx;
  logic access_phase;
  logic access_done;
  logic wr_lane0;
  logic idx_hit;
  logic [3:0] eff_offset;
  logic [3:0] next_half;
  logic [3:0] delayed_phase;
  logic [31:0] read_word;
  logic wr_ratio;
  logic wr_phase;
  logic wr_sync;
  logic capture_event;

  // Register index, the access phase, and the completing cycle in which pready already stands.
  assign reg_idx = paddr[ACD_IDX_LSB +: 10];
  assign access_phase = psel & penable;
  assign access_done = access_phase & state_reg.pready_reg;
  assign wr_lane0 = pwrite & pstrb[0];
  // A SYSREF edge is an event only while autophase is on; otherwise the divider ignores it.
  assign capture_event = sysref_rise & state_reg.autophase_en_reg; // [RULE6] [RULE8]

  // Address decode of every mapped register.
  always_comb begin
    unique case (reg_idx)
      ACD_IDX_RATIO_CONTROL,
      ACD_IDX_LOCAL_PHASE,
      ACD_IDX_SYNC_CONTROL,
      ACD_IDX_CAPTURED_PHASE,
      ACD_IDX_STATUS: idx_hit = 1'b1;
      default: idx_hit = 1'b0;
    endcase
  end

  // Write strobes per register; a write lands only at the completing edge with byte lane 0 enabled.
  // Read-only and unmapped words have no strobe, so a write to them is dropped without side effects.
  always_comb begin
    wr_ratio = 1'b0;
    wr_phase = 1'b0;
    wr_sync = 1'b0;
    if (access_done && wr_lane0) begin
      unique case (reg_idx)
        ACD_IDX_RATIO_CONTROL: begin
          wr_ratio = 1'b1;
        end
        ACD_IDX_LOCAL_PHASE: begin
          wr_phase = 1'b1;
        end
        ACD_IDX_SYNC_CONTROL: begin
          wr_sync = 1'b1;
        end
        default: begin
          wr_sync = 1'b0;
        end
      endcase
    end
  end

  // Offset actually applied; with autophase the captured phase is added modulo sixteen.
  // The divider then applies this offset modulo its own period, so offsets beyond one period wrap.
  always_comb begin
    if (state_reg.autophase_en_reg) begin
      eff_offset = state_reg.captured_phase_reg + state_reg.local_phase_reg; // [RULE7]
    end else begin
      eff_offset = state_reg.local_phase_reg; // [RULE2] [RULE3] [RULE4] [RULE5]
    end
  end

  // Read multiplexer; reserved bits and unmapped addresses read as zero.
  // The status word shows the live counter and divided level, only a snapshot of a moving divider.
  always_comb begin
    read_word = '0;
    unique case (reg_idx)
      ACD_IDX_RATIO_CONTROL: begin
        read_word[ACD_RATIO_LSB +: 2] = state_reg.ratio_code_reg;
      end
      ACD_IDX_LOCAL_PHASE: begin
        read_word[ACD_PHASE_LSB +: 4] = state_reg.local_phase_reg;
      end
      ACD_IDX_SYNC_CONTROL: begin
        read_word[ACD_AUTOPHASE_BIT] = state_reg.autophase_en_reg;
      end
      ACD_IDX_CAPTURED_PHASE: begin
        read_word[ACD_CAPT_LSB +: 4] = state_reg.captured_phase_reg;
      end
      ACD_IDX_STATUS: begin
        read_word[ACD_STAT_HALF_LSB +: 3] = state_reg.half_count_reg;
        read_word[ACD_STAT_DIV_BIT] = state_reg.div_clk_reg;
        read_word[ACD_STAT_AUTO_BIT] = state_reg.autophase_en_reg;
        read_word[ACD_STAT_EFF_LSB +: 4] = eff_offset;
        read_word[ACD_STAT_CNT_LSB +: 8] = state_reg.sysref_count_reg;
      end
      default: begin
        read_word = '0;
      end
    endcase
  end

  // Half-cycle counter advances on each sample clock edge and wraps at the divided period.
  // Without an edge the counter holds; masking also pulls it into range after a ratio change.
  always_comb begin
    if (sclk_edge) begin
      next_half = ({1'b0, state_reg.half_count_reg} + 4'h1) & period_mask(state_reg.ratio_code_reg); // [RULE1]
    end else begin
      next_half = {1'b0, state_reg.half_count_reg} & period_mask(state_reg.ratio_code_reg);
    end
  end

  // Each offset step delays the divided waveform by one half input cycle.
  assign delayed_phase = (next_half - eff_offset) & period_mask(state_reg.ratio_code_reg); // [RULE3] [RULE4]

  // Next-state logic of the whole block.
  always_comb begin
    state_next = state_reg;

    // Divider counter and divided clock.
    state_next.half_count_reg = next_half[2:0]; // [RULE1]
    state_next.div_clk_reg = phase_high(delayed_phase, state_reg.ratio_code_reg); // [RULE2] [RULE5]
    state_next.div_rise_reg = state_next.div_clk_reg & ~state_reg.div_clk_reg;

    // SYSREF capture only while autophase is on; otherwise the event is ignored.
    // The captured half-cycle count becomes part of the offset, which realigns the divider to the event.
    if (capture_event) begin
      state_next.captured_phase_reg = {1'b0, state_reg.half_count_reg}; // [RULE6] [RULE9]
      state_next.sysref_count_reg = state_reg.sysref_count_reg + 8'h01;
    end

    // One wait state: pready rises in the second access cycle and falls after the transfer.
    // Registering the answer keeps pready, pslverr and prdata straight from flops at the cost of that wait.
    state_next.pready_reg = access_phase & ~state_reg.pready_reg;
    if (access_phase && !state_reg.pready_reg) begin
      state_next.pslverr_reg = ~idx_hit;
      state_next.prdata_reg = pwrite ? '0 : read_word;
    end else if (access_done) begin
      state_next.pslverr_reg = 1'b0;
      state_next.prdata_reg = '0;
    end

    // Register writes take effect at the completing edge of the transfer.
    // A ratio change restarts nothing; the half-cycle counter is simply masked to the new period.
    if (wr_ratio) begin
      state_next.ratio_code_reg = pwdata[ACD_RATIO_LSB +: 2]; // [RULE1]
    end
    if (wr_phase) begin
      state_next.local_phase_reg = pwdata[ACD_PHASE_LSB +: 4];
    end
    if (wr_sync) begin
      state_next.autophase_en_reg = pwdata[ACD_AUTOPHASE_BIT]; // [RULE9]
    end
  end

  // Register all state.
  // Control registers clear with the rest, so the divider restarts at ratio one with no offset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.ratio_code_reg <= ACD_RATIO_RESET;
      state_reg.local_phase_reg <= ACD_PHASE_RESET;
      state_reg.autophase_en_reg <= ACD_AUTOPHASE_RESET;
      state_reg.captured_phase_reg <= ACD_CAPT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from flops.
  assign pready = state_reg.pready_reg;
  assign pslverr = state_reg.pslverr_reg;
  assign prdata = state_reg.prdata_reg;
  assign div_clk_out = state_reg.div_clk_reg;
  assign div_rise_out = state_reg.div_rise_reg;

endmodule

// ---- tb/acd_divider_sva.sv ----
// Checker of the APB answer timing, error decode and divided clock pulse of the clock divider.
`timescale 1ns/1ps
module acd_divider_sva (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB ports.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // Divided clock level and pulse.
  input wire logic div_clk_out,
  input wire logic div_rise_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  // Marks the register indices that answer without an error.
  assign mapped = paddr[11:2] inside {10'h108, 10'h109, 10'h10A, 10'h129, 10'h130};
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready missing after one wait state");
  property p_in_access; pready |-> psel && penable; endproperty
  a_in_access: assert property (p_in_access) else $error("pready outside an access");
  property p_after_access; pready |-> $past(psel && penable); endproperty
  a_after_access: assert property (p_after_access) else $error("pready without a wait state");
  property p_single; pready |=> !pready; endproperty
  a_single: assert property (p_single) else $error("pready longer than one cycle");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  property p_err_map; pready |-> pslverr == !mapped; endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr disagrees with address decode");
  property p_rdata_idle; !pready || pwrite |-> prdata == 32'h0000_0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero outside a read answer");
  property p_rise; div_rise_out |=> !div_rise_out; endproperty
  a_rise: assert property (p_rise) else $error("divided clock pulse too long");
  property p_rise_edge; div_rise_out |-> div_clk_out && !$past(div_clk_out); endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("divided clock pulse without a rise");
  c_read: cover property (pready && !pwrite && !pslverr);
  c_write: cover property (pready && pwrite);
  c_err: cover property (pslverr);
  c_rise: cover property (div_rise_out);
endmodule
bind acd_divider acd_divider_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .div_clk_out(div_clk_out), .div_rise_out(div_rise_out));

// ---- tb/acd_clk_src.sv ----
// Behavioural source of the sample clock and SYSREF pins that feeds the clock divider.
`timescale 1ns/1ps
module acd_clk_src (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Requests from the bench.
  input wire logic go,
  input wire logic [4:0] n_edges,
  input wire logic sref_go,
  // Pins toward the divider and a progress flag.
  output logic sclk,
  output logic sysref,
  output logic busy
);
  logic [4:0] left;
  logic [1:0] t;
  logic [1:0] s;
  // Each sample clock level stands three pclk cycles, so the pin synchroniser never misses an edge.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk <= 1'b0;
      left <= 5'h00;
      t <= 2'h0;
    end else if (go) begin
      left <= n_edges;
      t <= 2'h0;
    end else if (left != 5'h00) begin
      t <= (t == 2'h2) ? 2'h0 : t + 2'h1;
      if (t == 2'h2) begin
        sclk <= ~sclk;
        left <= left - 5'h01;
      end
    end
  end
  // SYSREF stands high for three pclk cycles while the sample clock is still.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysref <= 1'b0;
      s <= 2'h0;
    end else begin
      sysref <= sref_go || s > 2'h1;
      s <= sref_go ? 2'h3 : (s != 2'h0 ? s - 2'h1 : 2'h0);
    end
  end
  assign busy = left != 5'h00 || s != 2'h0;
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench of the clock divider driven over APB with a sample clock and SYSREF source.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import acd_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, sref_go = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, st;
  logic [3:0] pstrb = 4'hF;
  logic [4:0] n_edges = 0;
  logic pready, pslverr, er, sclk, sysref, busy, div_clk_out, div_rise_out;
  int err_count = 0, cmp_count = 0, R, m2, h, cap, e, dv, cnt;
  // Cases: ratio code, local phase, autophase, edges before and after SYSREF, SYSREF events.
  int cr[9] = '{0, 0, 1, 3, 3, 1, 3, 3, 2};
  int cp[9] = '{0, 1, 2, 14, 15, 3, 1, 5, 1};
  int ca[9] = '{0, 0, 0, 0, 0, 1, 0, 1, 0};
  int cn[9] = '{3, 3, 5, 6, 7, 3, 5, 5, 3};
  int cm[9] = '{0, 0, 0, 0, 0, 2, 3, 3, 0};
  int cs[9] = '{0, 0, 0, 0, 0, 1, 1, 2, 0};
  logic [11:0] ra[3] = '{12'h420, 12'h424, 12'h428};
  logic [31:0] rv[3] = '{32'h0000_0003, 32'h0000_000F, 32'h0000_0080};
  always #10 pclk = ~pclk;
  acd_divider DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .sample_clk_in(sclk), .sysref_in(sysref), .div_clk_out(div_clk_out), .div_rise_out(div_rise_out));
  acd_clk_src u_src (.pclk(pclk), .presetn(presetn), .go(go), .n_edges(n_edges), .sref_go(sref_go),
    .sclk(sclk), .sysref(sysref), .busy(busy));
  // Prints the counts and the verdict, then ends the run.
  task results;
    $display("errors=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer; holds the request until pready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
    if (i == 20) begin err_count++; results; end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Makes k sample clock edges, then optionally one SYSREF event, and lets the synchronisers settle.
  task run(input int k, input bit s);
    int i;
    @(posedge pclk);
    n_edges <= k[4:0];
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    // The source takes the request at this edge, so busy is only valid one edge later.
    @(posedge pclk);
    i = 0;
    while (busy !== 1'b0 && i < 200) begin @(posedge pclk); i++; end
    if (i == 200) begin err_count++; results; end
    repeat (6) @(posedge pclk);
    if (s) begin
      sref_go <= 1'b1;
      @(posedge pclk);
      sref_go <= 1'b0;
      repeat (8) @(posedge pclk);
    end
  endtask
  // Register reset values, reserved bits, refused accesses, then the divider case table.
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int j = 0; j < 3; j++) begin apb(0, ra[j], 0); `CHK(rd, 32'h0000_0000) end
    apb(0, 12'h4A4, 0); `CHK(rd, 32'h0000_0000)
    for (int j = 0; j < 3; j++) begin apb(1, ra[j], 32'h0000_00FF); apb(0, ra[j], 0); `CHK(rd, rv[j]) end
    pstrb <= 4'h0;
    apb(1, 12'h424, 32'h0000_0005);
    pstrb <= 4'hF;
    apb(0, 12'h424, 0); `CHK(rd, 32'h0000_000F)
    apb(1, 12'h4A4, 32'h0000_000F); apb(0, 12'h4A4, 0); `CHK(rd, 32'h0000_0000)
    apb(0, 12'h000, 0); `CHK({er, rd}, {1'b1, 32'h0000_0000})
    apb(1, 12'h000, 32'h0000_0001); `CHK(er, 1'b1)
    for (int c = 0; c < 9; c++) begin
      @(posedge pclk) presetn <= 1'b0;
      @(posedge pclk) presetn <= 1'b1;
      apb(1, 12'h420, cr[c]);
      apb(1, 12'h424, cp[c]);
      apb(1, 12'h428, ca[c] << 7);
      run(cn[c], cs[c] > 0);
      run(cm[c], cs[c] > 1);
      R = cr[c] == 3 ? 4 : (cr[c] == 1 ? 2 : 1);
      m2 = 2 * R;
      h = (cn[c] + cm[c]) % m2;
      cap = ca[c] == 0 ? 0 : (cs[c] == 2 ? h : cn[c] % m2);
      e = (cp[c] + cap) % 16;
      dv = ((h - e % m2 + m2) % m2) < R;
      cnt = ca[c] ? cs[c] : 0;
      st = {8'h00, cnt[7:0], 4'h0, e[3:0], 2'b00, ca[c][0], dv[0], 1'b0, h[2:0]};
      apb(0, 12'h4C0, 0); `CHK(rd, st)
      `CHK(div_clk_out, dv[0])
      apb(0, 12'h4A4, 0); `CHK(rd, cap)
    end
    results;
  end
endmodule
